// ==== delay_counter.v ====
// Purpose: Loadable down counter that emits a one-cycle done pulse.
// Assumes: Synchronous active-high reset.
// Notes:   A start while running restarts the count.
`timescale 1ns/1ps
`include "pwr_mode_map.vh"

module delay_counter #(
  parameter [`CNT_W-1:0] LENGTH = 16'h0001
) (
  input  wire clock_in,   // System clock.
  input  wire rst_in,     // Synchronous reset.
  input  wire start_in,   // Begin a new count.
  input  wire abort_in,   // Cancel a running count.
  output reg  busy_out,   // Count in progress.
  output reg  done_out    // One-cycle pulse at the end.
);

  reg [`CNT_W-1:0] count_q;

  // ****************************************************************
  // Counter
  // ****************************************************************
  // Counts LENGTH cycles, then pulses done once.
  always @(posedge clock_in) begin
    done_out <= 1'b0;
    if (rst_in || abort_in) begin
      count_q  <= {`CNT_W{1'b0}};
      busy_out <= 1'b0;
    end else if (start_in) begin
      count_q  <= LENGTH;
      busy_out <= 1'b1;
    end else if (busy_out) begin
      if (count_q <= 16'h0001) begin
        busy_out <= 1'b0;
        done_out <= 1'b1;
      end else begin
        count_q <= count_q - 16'h0001;
      end
    end
  end

endmodule

// ==== osc_core_model.sv ====
// Purpose: Oscillator blocks that report ready some cycles after enable.
// Assumes: Shares the system clock with the sequencer.
// Notes:   A slow start stretches the wait so gating on ready shows.
`timescale 1ns/1ps
module osc_core_model (
  input  wire clock_in,      // System clock.
  input  wire rst_in,        // Synchronous reset.
  input  wire slow_in,       // Stretch both start-ups.
  input  wire int_en_in,     // Internal block enable.
  input  wire sec_en_in,     // Secondary oscillator enable.
  output reg  int_ready_out, // Internal block usable.
  output reg  sec_ready_out  // Secondary oscillator usable.
);
  reg  [3:0] int_q;
  reg  [3:0] sec_q;
  wire [3:0] lim_w = slow_in ? 4'hA : 4'h1;
  // A disabled source loses its ready at once and restarts from zero.
  always @(posedge clock_in) begin
    int_q <= (rst_in || !int_en_in) ? 4'h0 : int_q + {3'h0, int_q != 4'hF};
    sec_q <= (rst_in || !sec_en_in) ? 4'h0 : sec_q + {3'h0, sec_q != 4'hF};
    int_ready_out <= !rst_in && int_en_in && int_q >= lim_w;
    sec_ready_out <= !rst_in && sec_en_in && sec_q >= lim_w;
  end
endmodule

// ==== pwr_mode_map.vh ====
// Purpose: Constants for the sleep and idle power mode sequencer.
// Assumes: One 250 MHz system clock, period 4 ns.
// Notes:   Delay times are in nanoseconds; cycle counts are sized for the counters.
`ifndef PWR_MODE_MAP_VH
`define PWR_MODE_MAP_VH

// ****************************************************************
// Clock and delay timing
// ****************************************************************
`define CLK_PERIOD_NS        4
`define CPU_READY_TIME_NS    2000
// The readiness count is the readiness time divided by the clock period.
`define CPU_READY_CYCLES     16'h01F4
`define OSC_STARTUP_CYCLES   16'h0400
`define PLL_LOCK_CYCLES      16'h0200
`define CNT_W                16

// ****************************************************************
// System clock select encodings
// ****************************************************************
`define SCS_PRIMARY          2'h0
`define SCS_SECONDARY        2'h1
`define SCS_INTERNAL         2'h2

// ****************************************************************
// Primary oscillator modes
// ****************************************************************
`define OSC_LOW_POWER_XTAL   3'h0
`define OSC_STANDARD_XTAL    3'h1
`define OSC_HIGH_SPEED_XTAL  3'h2
`define OSC_PLL_XTAL         3'h3
`define OSC_EXTERNAL_CLOCK   3'h4
`define OSC_RC               3'h5
`define OSC_INTERNAL_IO      3'h6

`endif

// ==== sleep_idle_power_mode_control.v ====
// Purpose: Sleep and idle power mode sequencer with wake-up delays.
// Assumes: Core, oscillators and watchdog share the system clock.
// Notes:   Clock gates and oscillator enables are registered outputs.
// Operation
// - Halt with idle select clear enters sleep.
// - Sleep stops oscillator, clears clock status bits.
// - Sleep entry performs no clock switch.
// - Watchdog RC and secondary oscillator keep running.
// - Sleep wake waits for selected source ready.
// - Two-speed or fail-safe wakes on internal oscillator.
// - Primary running flag set when primary clocks.
// - Wake keeps idle select and clock select.
// - Idle stops CPU clock, peripherals keep running.
// - Idle entry keeps clock status bits.
// - Idle exits only on interrupt, watchdog, reset.
// - Idle wake waits CPU readiness delay.
// - Idle exit runs from idle's clock source.
// - Watchdog wake enters currently selected run state.
// - Skip start-up timer for primary idle, non-crystal.
// - Readiness delay always applies; resume right after.
// - Readiness delay runs parallel with start-up timer.
// - Internal oscillator wake runs during its stabilization.
`timescale 1ns/1ps
`include "pwr_mode_map.vh"

module sleep_idle_power_mode_control #(
  parameter [`CNT_W-1:0] OST_CYCLES   = `OSC_STARTUP_CYCLES,
  parameter [`CNT_W-1:0] READY_CYCLES = `CPU_READY_CYCLES
) (
  input  wire       clock_in,                   // System clock.
  input  wire       rst_in,                     // Synchronous reset.
  input  wire       halt_instr_in,              // Power-down instruction executed.
  input  wire       idle_on_halt_select_in,     // Idle select bit from core.
  input  wire [1:0] system_clock_select_in,     // Clock source select field.
  input  wire [2:0] primary_osc_mode_in,        // Primary oscillator mode.
  input  wire       two_speed_startup_in,       // Two-speed start-up enabled.
  input  wire       fail_safe_monitor_in,       // Fail-safe clock monitor enabled.
  input  wire       watchdog_timer_enable_in,   // Watchdog selected.
  input  wire       secondary_timer_osc_en_in,  // Secondary timer oscillator enabled.
  input  wire       irq_in,                     // Pending interrupt.
  input  wire       wdt_timeout_in,             // Watchdog time-out.
  input  wire       soft_reset_in,              // Reset wake event.
  input  wire       internal_osc_ready_in,      // Internal oscillator usable.
  input  wire       secondary_osc_ready_in,     // Secondary oscillator usable.
  output reg        cpu_clock_en_out,           // CPU clock gate.
  output reg        periph_clock_en_out,        // Peripheral clock gate.
  output reg        primary_osc_en_out,         // Primary oscillator enable.
  output reg        internal_osc_en_out,        // Internal oscillator block enable.
  output reg        low_freq_internal_rc_en_out, // Low-frequency RC enable.
  output reg        secondary_osc_en_out,       // Secondary oscillator enable.
  output reg  [1:0] active_clock_source_out,    // Source supplying clocks.
  output reg        primary_clock_running_flag_out, // Primary clock running.
  output reg        internal_osc_stable_flag_out,   // Internal source status.
  output reg        sleeping_out,               // In full sleep.
  output reg        idling_out,                 // In an idle state.
  output reg        wdt_wake_out                // Last wake was watchdog.
);

  // ****************************************************************
  // States
  // ****************************************************************
  // Run moves to sleep or idle on a halt. A qualified wake moves to the wake
  // state, which keeps the CPU clock off until the readiness delay and the
  // selected source are both done, and then returns to run.
  // Codes above the wake state are unused and fall back to run.
  // The select inputs are only read here, so no state ever alters them.
  localparam [2:0] ST_RUN   = 3'h0;
  localparam [2:0] ST_SLEEP = 3'h1;
  localparam [2:0] ST_IDLE  = 3'h2;
  localparam [2:0] ST_WAKE  = 3'h3;

  reg  [2:0] state_q;
  reg  [2:0] state_d;
  reg  [1:0] idle_source_q;
  reg        from_sleep_q;
  reg        ost_needed_q;
  reg        ost_done_q;
  reg        ready_done_q;
  reg        ost_start;
  wire       wake;
  wire       wdt_cause;
  wire       ost_done;
  wire       ready_done;
  wire       crystal_mode;
  wire       early_internal;
  wire       source_ready;
  wire       wake_done;

  // Crystal and PLL crystal modes are the only ones needing start-up.
  assign crystal_mode = (primary_osc_mode_in == `OSC_LOW_POWER_XTAL) ||
                        (primary_osc_mode_in == `OSC_STANDARD_XTAL) ||
                        (primary_osc_mode_in == `OSC_HIGH_SPEED_XTAL) ||
                        (primary_osc_mode_in == `OSC_PLL_XTAL);
  // Either feature brings the internal block up at once after a sleep wake.
  assign early_internal = two_speed_startup_in || fail_safe_monitor_in;

  // ****************************************************************
  // Sub-blocks
  // ****************************************************************
  wake_source_filter u_wake (
    .clock_in       (clock_in),
    .rst_in         (rst_in),
    .irq_in         (irq_in),
    .wdt_timeout_in (wdt_timeout_in),
    .soft_reset_in  (soft_reset_in),
    .armed_in       ((state_q == ST_SLEEP) || (state_q == ST_IDLE)),
    .wake_out       (wake),
    .wdt_cause_out  (wdt_cause)
  );

  // Busy flags are not needed; the done pulses are latched instead.
  delay_counter #(.LENGTH(OST_CYCLES)) u_ost (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .start_in (ost_start),
    .abort_in (1'b0),
    .busy_out (),
    .done_out (ost_done)
  );

  // The readiness delay starts on the same wake pulse as the start-up timer.
  // Its done pulse lands LENGTH cycles after the wake pulse, so the CPU clock
  // returns a few cycles more than the readiness count after the cause.
  delay_counter #(.LENGTH(READY_CYCLES)) u_ready (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .start_in (wake),
    .abort_in (1'b0),
    .busy_out (),
    .done_out (ready_done)
  );

  // Start-up timer only for a primary crystal source woken from sleep.
  always @* begin
    ost_start = wake && from_sleep_q && crystal_mode && !early_internal &&
                (system_clock_select_in == `SCS_PRIMARY);
  end

  // ****************************************************************
  // Readiness of the selected source
  // ****************************************************************
  // Internal oscillator counts as ready at once; execution runs during settle.
  assign source_ready =
    !from_sleep_q || early_internal ? 1'b1 :
    (system_clock_select_in == `SCS_PRIMARY)   ? (!ost_needed_q || ost_done_q) :
    (system_clock_select_in == `SCS_SECONDARY) ? secondary_osc_ready_in :
    1'b1;
  assign wake_done = ready_done_q && source_ready;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (halt_instr_in && idle_on_halt_select_in) begin
          state_d = ST_IDLE;
        end else if (halt_instr_in) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake) begin
          state_d = ST_WAKE;
        end
      end
      ST_IDLE: begin
        if (wake) begin
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (wake_done) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // ****************************************************************
  // Sequencer registers
  // ****************************************************************
  // Mode select inputs are only read, never written, so wake leaves them alone.
  always @(posedge clock_in) begin
    if (rst_in) begin
      state_q       <= ST_RUN;
      idle_source_q <= `SCS_PRIMARY;
      from_sleep_q  <= 1'b0;
      ost_needed_q  <= 1'b0;
      ost_done_q    <= 1'b0;
      ready_done_q  <= 1'b0;
      wdt_wake_out  <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q == ST_RUN && halt_instr_in) begin
        idle_source_q <= system_clock_select_in;
        from_sleep_q  <= !idle_on_halt_select_in;
        ost_done_q    <= 1'b0;
        ready_done_q  <= 1'b0;
      end
      if (ost_start) begin
        ost_needed_q <= 1'b1;
      end else if (wake) begin
        ost_needed_q <= 1'b0;
      end
      if (ost_done) begin
        ost_done_q <= 1'b1;
      end
      if (ready_done) begin
        ready_done_q <= 1'b1;
      end
      if (wake) begin
        wdt_wake_out <= wdt_cause;
      end
    end
  end

  // ****************************************************************
  // Clock gates, oscillator enables and status
  // ****************************************************************
  // Outputs follow the next state so they settle with it.
  always @(posedge clock_in) begin
    if (rst_in) begin
      cpu_clock_en_out               <= 1'b1;
      periph_clock_en_out            <= 1'b1;
      primary_osc_en_out             <= 1'b1;
      internal_osc_en_out            <= 1'b0;
      low_freq_internal_rc_en_out    <= 1'b0;
      secondary_osc_en_out           <= 1'b0;
      active_clock_source_out        <= `SCS_PRIMARY;
      primary_clock_running_flag_out <= 1'b1;
      internal_osc_stable_flag_out   <= 1'b0;
      sleeping_out                   <= 1'b0;
      idling_out                     <= 1'b0;
    end else begin
      sleeping_out <= (state_d == ST_SLEEP);
      idling_out   <= (state_d == ST_IDLE);
      low_freq_internal_rc_en_out <= watchdog_timer_enable_in;
      // A selected secondary source stops in sleep unless its timer keeps it on.
      secondary_osc_en_out        <= secondary_timer_osc_en_in ||
                                     ((system_clock_select_in == `SCS_SECONDARY) &&
                                      (state_d != ST_SLEEP));
      case (state_d)
        ST_SLEEP: begin
          // Stop CPU and peripheral clocks, primary and internal oscillators directly, no switch to another clock first.
          cpu_clock_en_out               <= 1'b0;
          periph_clock_en_out            <= 1'b0;
          primary_osc_en_out             <= 1'b0;
          internal_osc_en_out            <= 1'b0;
          primary_clock_running_flag_out <= 1'b0;
          internal_osc_stable_flag_out   <= 1'b0;
        end
        ST_IDLE: begin
          // Status bits untouched; peripherals keep their source.
          cpu_clock_en_out    <= 1'b0;
          periph_clock_en_out <= 1'b1;
        end
        ST_WAKE: begin
          // CPU stays gated; peripherals run only where a clock is already valid.
          cpu_clock_en_out    <= 1'b0;
          primary_osc_en_out  <= (system_clock_select_in == `SCS_PRIMARY);
          internal_osc_en_out <= (system_clock_select_in == `SCS_INTERNAL) || early_internal;
          if (from_sleep_q && early_internal) begin
            periph_clock_en_out     <= 1'b1;
            active_clock_source_out <= `SCS_INTERNAL;
          end else begin
            periph_clock_en_out <= !from_sleep_q;
          end
        end
        ST_RUN: begin
          cpu_clock_en_out    <= 1'b1;
          periph_clock_en_out <= 1'b1;
          if (state_q == ST_WAKE) begin
            // Idle resumes its own source; sleep resumes the selected one.
            active_clock_source_out <= from_sleep_q ? system_clock_select_in : idle_source_q;
            primary_clock_running_flag_out <=
              ((from_sleep_q ? system_clock_select_in : idle_source_q) == `SCS_PRIMARY);
            internal_osc_stable_flag_out <=
              ((from_sleep_q ? system_clock_select_in : idle_source_q) == `SCS_INTERNAL) &&
              internal_osc_ready_in;
          end else begin
            // Plain run tracks the select field as the core writes it.
            active_clock_source_out        <= system_clock_select_in;
            primary_osc_en_out             <= 1'b1;
            internal_osc_en_out            <= (system_clock_select_in == `SCS_INTERNAL);
            primary_clock_running_flag_out <= (system_clock_select_in == `SCS_PRIMARY);
            internal_osc_stable_flag_out   <= (system_clock_select_in == `SCS_INTERNAL) &&
                                              internal_osc_ready_in;
          end
        end
        default: begin
          cpu_clock_en_out <= 1'b1;
        end
      endcase
    end
  end

endmodule

// ==== sleep_idle_power_mode_control_chk.sv ====
// Purpose: Port-level concurrent checks for the sleep and idle sequencer.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Delay figures come from the bound instance's parameters.
`timescale 1ns/1ps
module sleep_idle_power_mode_control_chk #(
  parameter [15:0] OST_CYCLES   = 16'h0400,
  parameter [15:0] READY_CYCLES = 16'h01F4
) (
  input wire       clock_in,
  input wire       rst_in,
  input wire       halt_instr_in,
  input wire       idle_on_halt_select_in,
  input wire [1:0] system_clock_select_in,
  input wire       two_speed_startup_in,
  input wire       fail_safe_monitor_in,
  input wire       watchdog_timer_enable_in,
  input wire       secondary_timer_osc_en_in,
  input wire       irq_in,
  input wire       wdt_timeout_in,
  input wire       soft_reset_in,
  input wire       secondary_osc_ready_in,
  input wire       cpu_clock_en_out,
  input wire       periph_clock_en_out,
  input wire       low_freq_internal_rc_en_out,
  input wire       secondary_osc_en_out,
  input wire [1:0] active_clock_source_out,
  input wire       primary_clock_running_flag_out,
  input wire       internal_osc_stable_flag_out,
  input wire       sleeping_out,
  input wire       idling_out,
  input wire       wdt_wake_out
);
  wire       run_w   = !sleeping_out && !idling_out && cpu_clock_en_out;
  wire       cause_w = irq_in || wdt_timeout_in || soft_reset_in;
  reg [15:0] off_q;
  reg [1:0]  idle_src_q;
  reg        from_idle_q;
  // Counts gated wake cycles and remembers the source and kind of the last halt.
  always @(posedge clock_in) begin
    if (rst_in) begin
      off_q <= 16'h0000;
      idle_src_q <= 2'h0;
      from_idle_q <= 1'b0;
    end else begin
      off_q <= (cpu_clock_en_out || sleeping_out || idling_out) ? 16'h0000 : off_q + 16'h0001;
      if (run_w && halt_instr_in) begin
        idle_src_q <= active_clock_source_out;
        from_idle_q <= idle_on_halt_select_in;
      end
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence s_halt(sel); run_w && halt_instr_in && idle_on_halt_select_in == sel; endsequence
  sequence s_quiet; idling_out && !cause_w; endsequence
  property p_enter_sleep; s_halt(1'b0) |=> sleeping_out && !idling_out && !cpu_clock_en_out; endproperty
  a_enter_sleep: assert property (p_enter_sleep) else $error("halt did not enter sleep");
  property p_sleep_status; s_halt(1'b0) |=> !primary_clock_running_flag_out && !internal_osc_stable_flag_out; endproperty
  a_sleep_status: assert property (p_sleep_status) else $error("status kept in sleep");
  property p_sleep_no_clock; $rose(sleeping_out) |-> !cpu_clock_en_out && !periph_clock_en_out; endproperty
  a_sleep_no_clock: assert property (p_sleep_no_clock) else $error("clock left on in sleep");
  property p_keep_osc; sleeping_out || idling_out |-> low_freq_internal_rc_en_out == $past(watchdog_timer_enable_in)
    && (secondary_osc_en_out || !$past(secondary_timer_osc_en_in)); endproperty
  a_keep_osc: assert property (p_keep_osc) else $error("low power source stopped");
  property p_sleep_wait; !cpu_clock_en_out && !sleeping_out && !idling_out && !from_idle_q && !secondary_osc_ready_in
    && system_clock_select_in == 2'h1 && !two_speed_startup_in && !fail_safe_monitor_in |=> !cpu_clock_en_out; endproperty
  a_sleep_wait: assert property (p_sleep_wait) else $error("cpu clocked before source ready");
  property p_primary_flag; cpu_clock_en_out && $past(cpu_clock_en_out) && active_clock_source_out == 2'h0
    && $stable(active_clock_source_out) |-> primary_clock_running_flag_out; endproperty
  a_primary_flag: assert property (p_primary_flag) else $error("primary flag low");
  property p_enter_idle; s_halt(1'b1) |=> idling_out && !cpu_clock_en_out && periph_clock_en_out; endproperty
  a_enter_idle: assert property (p_enter_idle) else $error("halt did not enter idle");
  property p_idle_flags; s_halt(1'b1) |=> $stable(primary_clock_running_flag_out) && $stable(internal_osc_stable_flag_out); endproperty
  a_idle_flags: assert property (p_idle_flags) else $error("status changed on idle");
  property p_idle_hold; s_quiet ##1 s_quiet |=> idling_out; endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle left without cause");
  property p_ready_delay; $rose(cpu_clock_en_out) |-> off_q >= READY_CYCLES; endproperty
  a_ready_delay: assert property (p_ready_delay) else $error("readiness delay cut short");
  property p_idle_source; $rose(cpu_clock_en_out) && from_idle_q |-> active_clock_source_out == idle_src_q; endproperty
  a_idle_source: assert property (p_idle_source) else $error("idle exit changed source");
  property p_wdt_wake; (sleeping_out || idling_out) && wdt_timeout_in && !irq_in && !soft_reset_in |-> ##[1:3] wdt_wake_out;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake not flagged");
endmodule
bind sleep_idle_power_mode_control sleep_idle_power_mode_control_chk #(
  .OST_CYCLES(OST_CYCLES), .READY_CYCLES(READY_CYCLES)) chk_u (.*);

// ==== sleep_idle_power_mode_control_tb.sv ====
// Purpose: Self-checking bench for the sleep and idle sequencer.
// Assumes: Short delay parameters keep the run brief.
// Notes:   Every select and oscillator mode is halted and woken.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module sleep_idle_power_mode_control_tb;
  localparam [15:0] OSCILLATOR_STARTUP_TIMER = 16'h0010;
  localparam [15:0] RDY = 16'h0006;
  reg        clock_in = 1'b0;
  reg        rst_in = 1'b1;
  reg        halt_instr_in = 1'b0;
  reg        idle_on_halt_select_in = 1'b0;
  reg  [1:0] system_clock_select_in = 2'h0;
  reg  [2:0] primary_osc_mode_in = 3'h0;
  reg        two_speed_startup_in = 1'b0;
  reg        fail_safe_monitor_in = 1'b0;
  reg        watchdog_timer_enable_in = 1'b0;
  reg        secondary_timer_osc_en_in = 1'b0;
  reg        irq_in = 1'b0;
  reg        wdt_timeout_in = 1'b0;
  reg        soft_reset_in = 1'b0;
  reg        slow = 1'b0;
  wire       internal_osc_ready_in;
  wire       secondary_osc_ready_in;
  wire       cpu_clock_en_out;
  wire       periph_clock_en_out;
  wire       primary_osc_en_out;
  wire       internal_osc_en_out;
  wire       low_freq_internal_rc_en_out;
  wire       secondary_osc_en_out;
  wire [1:0] active_clock_source_out;
  wire       primary_clock_running_flag_out;
  wire       internal_osc_stable_flag_out;
  wire       sleeping_out;
  wire       idling_out;
  wire       wdt_wake_out;
  int        fails = 0;
  int        cmp_count = 0;
  int        n;
  int        cause;
  bit        idle;
  bit        oscillator_startup_timer;
  sleep_idle_power_mode_control #(.OST_CYCLES(OSCILLATOR_STARTUP_TIMER), .READY_CYCLES(RDY)) dut_u (.*);
  osc_core_model osc_u (.clock_in(clock_in), .rst_in(rst_in), .slow_in(slow), .int_en_in(internal_osc_en_out),
    .sec_en_in(secondary_osc_en_out), .int_ready_out(internal_osc_ready_in), .sec_ready_out(secondary_osc_ready_in));
  // The 4 ns system clock.
  initial forever #2 clock_in = ~clock_in;
  task automatic step(input int k);
    repeat (k) @(posedge clock_in);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Holds reset for 20 cycles, then expects the run state on the primary source.
  task automatic do_reset;
    rst_in = 1'b1;
    step(20);
    rst_in = 1'b0;
    `CHK({cpu_clock_en_out, periph_clock_en_out, primary_osc_en_out, active_clock_source_out,
          primary_clock_running_flag_out, sleeping_out, idling_out}, 8'hE4)
  endtask
  task automatic halt_pulse;
    halt_instr_in = 1'b1;
    step(1);
    halt_instr_in = 1'b0;
    step(1);
  endtask
  // Each pass halts into sleep or idle, tries a stray halt, wakes and times the return.
  initial begin
    void'($urandom(86));
    do_reset();
    for (int i = 0; i < 21; i++) begin
      idle = $urandom % 2;
      cause = i % 3;
      idle_on_halt_select_in = idle;
      system_clock_select_in = 2'((i / 7) % 3);
      primary_osc_mode_in = 3'(i % 7);
      two_speed_startup_in = ($urandom % 4) == 0;
      fail_safe_monitor_in = ($urandom % 5) == 0;
      watchdog_timer_enable_in = $urandom % 2;
      secondary_timer_osc_en_in = $urandom % 2;
      slow = $urandom % 2;
      step(20);
      halt_pulse();
      `CHK({sleeping_out, idling_out, cpu_clock_en_out, periph_clock_en_out}, {!idle, idle, 1'b0, idle})
      if (!idle) `CHK({primary_clock_running_flag_out, internal_osc_stable_flag_out, primary_osc_en_out,
                       internal_osc_en_out}, 4'h0)
      halt_pulse();
      step(5);
      `CHK({sleeping_out, idling_out, low_freq_internal_rc_en_out, secondary_osc_en_out},
           {!idle, idle, watchdog_timer_enable_in,
            secondary_timer_osc_en_in || (idle && system_clock_select_in == 2'h1)})
      irq_in = cause == 0;
      wdt_timeout_in = cause == 1;
      soft_reset_in = cause == 2;
      n = 0;
      do begin
        step(1);
        n++;
        {irq_in, wdt_timeout_in, soft_reset_in} = 3'h0;
      end while (cpu_clock_en_out !== 1'b1 && n < 800);
      if (n >= 800) begin
        fails++;
        tally_and_finish();
      end
      oscillator_startup_timer = !idle && system_clock_select_in == 2'h0 && primary_osc_mode_in <= 3'h3 && !two_speed_startup_in
            && !fail_safe_monitor_in;
      `CHK(n >= RDY, 1'b1)
      if (oscillator_startup_timer) `CHK(n >= OSCILLATOR_STARTUP_TIMER, 1'b1)
      if (system_clock_select_in != 2'h1 && !(oscillator_startup_timer && primary_osc_mode_in == 3'h3))
        `CHK(n <= (oscillator_startup_timer ? OSCILLATOR_STARTUP_TIMER + RDY : RDY + 5), 1'b1)
      `CHK(wdt_wake_out, cause == 1)
      step(primary_osc_mode_in == 3'h3 ? 600 : 40);
      `CHK({active_clock_source_out, primary_clock_running_flag_out, primary_osc_en_out, internal_osc_en_out},
           {system_clock_select_in, system_clock_select_in == 2'h0, 1'b1,
            system_clock_select_in == 2'h2})
      $display("test %0d done", i);
    end
    idle_on_halt_select_in = 1'b0;
    halt_pulse();
    do_reset();
    $display("test reset in sleep done");
    tally_and_finish();
  end
endmodule

// ==== wake_source_filter.v ====
// Purpose: Qualifies wake events; only interrupt, watchdog or reset count.
// Assumes: Event inputs are synchronous pulses or levels.
// Notes:   Output is registered, one cycle after the cause.
`timescale 1ns/1ps

module wake_source_filter (
  input  wire clock_in,         // System clock.
  input  wire rst_in,           // Synchronous reset.
  input  wire irq_in,           // Pending enabled interrupt.
  input  wire wdt_timeout_in,   // Watchdog time-out.
  input  wire soft_reset_in,    // Reset request while in low power.
  input  wire armed_in,         // Sequencer is asleep or idle.
  output reg  wake_out,         // Wake pulse, two cycles for a held cause.
  output reg  wdt_cause_out     // Wake came from the watchdog.
);

  // ****************************************************************
  // Wake qualification
  // ****************************************************************
  // Any other activity is ignored while armed.
  always @(posedge clock_in) begin
    if (rst_in) begin
      wake_out      <= 1'b0;
      wdt_cause_out <= 1'b0;
    end else begin
      wake_out      <= armed_in && (irq_in || wdt_timeout_in || soft_reset_in);
      wdt_cause_out <= armed_in && wdt_timeout_in;
    end
  end

endmodule
